// ### verilog/smtb_params.svh
// Constants for the site monitor test beacon control block
`ifndef SMTB_PARAMS_SVH
`define SMTB_PARAMS_SVH
// ==========================================================
// Timing
`define SMTB_CLK_MHZ 125
`define SMTB_CW_MAX_US 200
`define SMTB_TX_OFF_MS 100
// ==========================================================
// Setting selects
`define SMTB_CFG_ADDR 5'h00
`define SMTB_CFG_ALTFT 5'h01
`define SMTB_CFG_ALTST 5'h02
`define SMTB_CFG_MODEA 5'h03
`define SMTB_CFG_MODEAT 5'h04
`define SMTB_CFG_ACID 5'h05
`define SMTB_CFG_ACIDT 5'h06
`define SMTB_CFG_ALERTRR 5'h07
`define SMTB_CFG_CAP 5'h08
`define SMTB_CFG_CAPT 5'h09
`define SMTB_CFG_RAT 5'h0A
`define SMTB_CFG_RANGE 5'h0B
`define SMTB_CFG_ATTEN 5'h0C
`define SMTB_CFG_RXTRIG 5'h0D
`define SMTB_CFG_TURN 5'h0E
`define SMTB_CFG_ONGND 5'h0F
`define SMTB_CFG_GROUND 5'h10
// ==========================================================
// Limits and reset values
`define SMTB_ATTEN_MAX 6'h28
`define SMTB_RXTRIG_MAX 6'h28
`define SMTB_ALERTRR_MIN 5'h10
`define SMTB_ALERTRR_RST 5'h1F
`define SMTB_ALT_MARGIN_FT 18'h001F4
`define SMTB_ALT_HI_LO_FT 18'h13880
`define SMTB_ALT_HI_HI_FT 18'h1EC30
`define SMTB_COMBO_BAD 2'h3
// ==========================================================
// Control protocol
`define SMTB_MSP_CH 6'h06
`define SMTB_MSP_SR 8'h02
`define SMTB_MA_KEY 8'hFE
`define SMTB_CMD_ALERT 8'h01
`define SMTB_CMD_CAP 8'h02
`define SMTB_CMD_ID 8'h03
`define SMTB_CMD_RA 8'h04
`define SMTB_CMD_LOCK 8'h05
`define SMTB_CMD_UNLOCK 8'h06
`define SMTB_CMD_RESTORE 8'h07
// ==========================================================
// Register codes for ground-initiated reads
`define SMTB_BDS_CAP 8'h10
`define SMTB_BDS_ID 8'h20
`define SMTB_BDS_RA 8'h30
`define SMTB_BDS_LOCK 8'hE1
`define SMTB_BDS_STAT 8'hE2
`endif

// ### verilog/smtb_pkg.sv
// Types for the site monitor test beacon control block
package smtb_pkg;
  typedef enum logic [2:0] {
    SMTB_K_ACONLY = 3'h0,
    SMTB_K_ALLCALL = 3'h1,
    SMTB_K_MODEAC = 3'h2,
    SMTB_K_SURV = 3'h3,
    SMTB_K_COMMA = 3'h4,
    SMTB_K_MSP = 3'h5
  } smtb_kind_type;

  typedef enum logic [2:0] {
    SMTB_S_IDLE = 3'h1,
    SMTB_S_WAIT = 3'h2,
    SMTB_S_SEND = 3'h4
  } smtb_fsm_type;

  typedef struct packed {
    logic [16:0] cnt;
    logic run;
    logic done;
  } smtb_dly_type;

  typedef struct packed {
    smtb_fsm_type fsm;
    logic [2:0] kind;
    logic [23:0] addr;
    logic [16:0] altFt;
    logic [8:0] altSt;
    logic [11:0] modeA;
    logic [11:0] modeAT;
    logic [47:0] acId;
    logic [47:0] acIdT;
    logic [4:0] alertRr;
    logic [55:0] cap;
    logic [55:0] capT;
    logic [55:0] raT;
    logic [15:0] range;
    logic [5:0] atten;
    logic [5:0] rxTrig;
    logic [15:0] turn;
    logic onGnd;
    logic [16:0] groundFt;
    logic alert;
    logic capSel;
    logic idSel;
    logic raSel;
    logic capPend;
    logic locked;
    logic [7:0] lockIiSi;
    logic dlyStart;
    logic replyStrobe;
    logic [2:0] replyKind;
    logic replyAlert;
    logic replyCap;
    logic aicbValid;
    logic [55:0] aicbMb;
    logic elmValid;
    logic [79:0] elmData;
    logic raBroadcast;
    logic gicbAck;
    logic [55:0] gicbData;
    logic cfgAck;
    logic cfgError;
    logic [23:0] cwCnt;
    logic cwFault;
    logic txEnable;
  } smtb_state_type;
endpackage

// ### verilog/smtb_dly_if.sv
// Carrier between the control core and its reply delay timer
`timescale 1ns/1ps
interface smtb_dly_if;
  logic start;
  logic [16:0] cycles;
  logic done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface

// ### verilog/smtb_delay.sv
// Reply delay timer: counts the added turnaround and range delay
`timescale 1ns/1ps
module smtb_delay
  import smtb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  smtb_dly_if.tmr dly
);
  smtb_dly_type s_reg;
  smtb_dly_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (dly.start) begin
      s_next.cnt = dly.cycles;
      s_next.run = 1'b1;
    end else if (s_reg.run) begin
      if (s_reg.cnt == 17'h00000) begin
        s_next.run = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 17'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dly.done = s_reg.done;
endmodule

// ### verilog/smtb_top.sv
// Site monitor test beacon control: command decode, test actions, reply shaping
// Functional notes
// - Detect unbroken reply carrier and switch the transmitter off within 100 ms.
// - Accept commands in uplink specific protocol channel 6 with SR 2.
// - Accept commands as a chosen RR value or keyed Comm-A MA content.
// - Echo received Comm-A content that carries no command as an air-initiated Comm-B.
// - Echo extended length uplink segments back as downlink segments.
// - Alert command sets the alert bit as if identity changed.
// - Capability command selects test value and announces capability change.
// - Identification command selects the test identification.
// - Advisory command loads test advisory and triggers advisory broadcast.
// - Lockout register reports the locked-out II/SI code.
// - Status register readable by ground-initiated read.
// - Hold all user-programmable operating settings.
// - Reject any setting write outside its permitted range.
// - Report vertical status on the ground by default.
// - Still reply to all-call and Mode A/C while on ground.
// - Keep squitters disabled.
// - Status altitude codes use only illegal C/D combinations.
// - Reported altitude 500 ft below ground or in high band.
// - Programmable range delay; no new interrogation taken while it runs.
// - Reply to Mode A/C-only all-call interrogations.
// - Enter and leave all-call lockout at once on command.
// - Add programmable extra turnaround delay to each reply.
`timescale 1ns/1ps
`include "smtb_params.svh"
module smtb_top
  import smtb_pkg::*;
#(
  parameter int CW_CYCLES = `SMTB_CW_MAX_US * `SMTB_CLK_MHZ
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic intValid,
  input wire logic [2:0] intKind,
  input wire logic [4:0] intRr,
  input wire logic [55:0] intMa,
  input wire logic [5:0] intMspCh,
  input wire logic [7:0] intMspSr,
  input wire logic elmInValid,
  input wire logic [79:0] elmInData,
  input wire logic gicbValid,
  input wire logic [7:0] gicbBds,
  input wire logic cfgWe,
  input wire logic [4:0] cfgSel,
  input wire logic [55:0] cfgData,
  input wire logic txCarrierOn,
  output logic replyStrobe,
  output logic [2:0] replyKind,
  output logic replyAlert,
  output logic replyCapAnnounce,
  output logic replyOnGround,
  output logic replyAltStatus,
  output logic [11:0] replyAltDigits,
  output logic [16:0] replyAltFeet,
  output logic [11:0] replyModeA,
  output logic [23:0] beaconAddress,
  output logic aicbValid,
  output logic [55:0] aicbMb,
  output logic elmEchoValid,
  output logic [79:0] elmEchoData,
  output logic raBroadcast,
  output logic gicbAck,
  output logic [55:0] gicbData,
  output logic cfgAck,
  output logic cfgError,
  output logic [5:0] powerAtten,
  output logic [5:0] rxTrigLevel,
  output logic squitterEnable,
  output logic txEnable,
  output logic cwFault,
  output logic busy
);
  localparam logic [23:0] CW_LIMIT = 24'(CW_CYCLES);

  smtb_state_type s_reg;
  smtb_state_type s_next;
  smtb_dly_if dlyBus ();

  smtb_delay u_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .dly(dlyBus)
  );

  // ==========================================================
  // Command and setting decode
  logic accept;
  logic isCmd;
  logic [7:0] cmd;
  logic [7:0] cmdArg;
  logic cfgOk;
  logic [17:0] altPlus;
  logic [2:0] digC;
  logic [2:0] digD;

  always_comb begin
    accept = intValid && (s_reg.fsm == SMTB_S_IDLE);
    isCmd = 1'b0;
    cmd = 8'h00;
    cmdArg = 8'h00;
    if (intKind == SMTB_K_MSP && intMspCh == `SMTB_MSP_CH && intMspSr == `SMTB_MSP_SR) begin
      isCmd = 1'b1;
      cmd = intMa[55:48];
      cmdArg = intMa[47:40];
    end else if (intKind == SMTB_K_COMMA && intMa[55:48] == `SMTB_MA_KEY) begin
      isCmd = 1'b1;
      cmd = intMa[47:40];
      cmdArg = intMa[39:32];
    end else if ((intKind == SMTB_K_SURV || intKind == SMTB_K_COMMA) && intRr == s_reg.alertRr) begin
      isCmd = 1'b1;
      cmd = `SMTB_CMD_ALERT;
    end
  end

  // Altitude must sit below ground by the margin or in the high band
  always_comb begin
    altPlus = {1'b0, cfgData[16:0]} + `SMTB_ALT_MARGIN_FT;
    cfgOk = 1'b1;
    unique case (cfgSel)
      `SMTB_CFG_ALTFT: begin
        cfgOk = (altPlus <= {1'b0, s_reg.groundFt}) ||
                ({1'b0, cfgData[16:0]} >= `SMTB_ALT_HI_LO_FT &&
                 {1'b0, cfgData[16:0]} <= `SMTB_ALT_HI_HI_FT);
      end
      `SMTB_CFG_ALTST: cfgOk = cfgData[7:6] != `SMTB_COMBO_BAD;
      `SMTB_CFG_ALERTRR: cfgOk = cfgData[4:0] >= `SMTB_ALERTRR_MIN;
      `SMTB_CFG_ATTEN: cfgOk = cfgData[5:0] <= `SMTB_ATTEN_MAX;
      `SMTB_CFG_RXTRIG: cfgOk = cfgData[5:0] <= `SMTB_RXTRIG_MAX;
      `SMTB_CFG_ADDR, `SMTB_CFG_MODEA, `SMTB_CFG_MODEAT, `SMTB_CFG_ACID, `SMTB_CFG_ACIDT,
      `SMTB_CFG_CAP, `SMTB_CFG_CAPT, `SMTB_CFG_RAT, `SMTB_CFG_RANGE, `SMTB_CFG_TURN,
      `SMTB_CFG_ONGND, `SMTB_CFG_GROUND: cfgOk = 1'b1;
      default: cfgOk = 1'b0;
    endcase
  end

  // C/D pairs that no altitude decoder accepts
  always_comb begin
    unique case (s_reg.altSt[7:6])
      2'h1: begin
        digC = 3'h5;
        digD = 3'h7;
      end
      2'h2: begin
        digC = 3'h7;
        digD = 3'h7;
      end
      default: begin
        digC = 3'h0;
        digD = 3'h0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.dlyStart = 1'b0;
    s_next.replyStrobe = 1'b0;
    s_next.aicbValid = 1'b0;
    s_next.elmValid = 1'b0;
    s_next.raBroadcast = 1'b0;
    s_next.gicbAck = 1'b0;
    s_next.cfgAck = 1'b0;

    if (cfgWe) begin
      s_next.cfgAck = 1'b1;
      s_next.cfgError = !cfgOk;
      if (cfgOk) begin
        unique case (cfgSel)
          `SMTB_CFG_ADDR: s_next.addr = cfgData[23:0];
          `SMTB_CFG_ALTFT: s_next.altFt = cfgData[16:0];
          `SMTB_CFG_ALTST: s_next.altSt = cfgData[8:0];
          `SMTB_CFG_MODEA: s_next.modeA = cfgData[11:0];
          `SMTB_CFG_MODEAT: s_next.modeAT = cfgData[11:0];
          `SMTB_CFG_ACID: s_next.acId = cfgData[47:0];
          `SMTB_CFG_ACIDT: s_next.acIdT = cfgData[47:0];
          `SMTB_CFG_ALERTRR: s_next.alertRr = cfgData[4:0];
          `SMTB_CFG_CAP: s_next.cap = cfgData;
          `SMTB_CFG_CAPT: s_next.capT = cfgData;
          `SMTB_CFG_RAT: s_next.raT = cfgData;
          `SMTB_CFG_RANGE: s_next.range = cfgData[15:0];
          `SMTB_CFG_ATTEN: s_next.atten = cfgData[5:0];
          `SMTB_CFG_RXTRIG: s_next.rxTrig = cfgData[5:0];
          `SMTB_CFG_TURN: s_next.turn = cfgData[15:0];
          `SMTB_CFG_ONGND: s_next.onGnd = cfgData[0];
          `SMTB_CFG_GROUND: s_next.groundFt = cfgData[16:0];
          default: s_next.cfgError = 1'b1;
        endcase
      end
    end

    if (elmInValid) begin
      s_next.elmValid = 1'b1;
      s_next.elmData = elmInData;
    end

    if (gicbValid) begin
      s_next.gicbAck = 1'b1;
      unique case (gicbBds)
        `SMTB_BDS_CAP: s_next.gicbData = s_reg.capSel ? s_reg.capT : s_reg.cap;
        `SMTB_BDS_ID: s_next.gicbData = {8'h00, s_reg.idSel ? s_reg.acIdT : s_reg.acId};
        `SMTB_BDS_RA: s_next.gicbData = s_reg.raSel ? s_reg.raT : 56'h0;
        `SMTB_BDS_LOCK: s_next.gicbData = {s_reg.locked, 47'h0, s_reg.lockIiSi};
        `SMTB_BDS_STAT: s_next.gicbData = {s_reg.cwFault, s_reg.txEnable, s_reg.locked,
                                           s_reg.alert, s_reg.capSel, s_reg.idSel, s_reg.raSel,
                                           s_reg.cfgError, s_reg.onGnd, 47'h0};
        default: s_next.gicbData = 56'h0;
      endcase
    end

    unique case (s_reg.fsm)
      SMTB_S_IDLE: begin
        if (accept) begin
          s_next.kind = intKind;
          // Locked-out all-calls are dropped; other kinds are answered while txEnable holds
          if (!(intKind == SMTB_K_ALLCALL && s_reg.locked)) begin
            s_next.fsm = SMTB_S_WAIT;
            s_next.dlyStart = 1'b1;
          end
          if (isCmd) begin
            unique case (cmd)
              `SMTB_CMD_ALERT: begin
                s_next.alert = 1'b1;
              end
              `SMTB_CMD_CAP: begin
                s_next.capSel = 1'b1;
                s_next.capPend = 1'b1;
              end
              `SMTB_CMD_ID: s_next.idSel = 1'b1;
              `SMTB_CMD_RA: begin
                s_next.raSel = 1'b1;
                s_next.raBroadcast = 1'b1;
              end
              `SMTB_CMD_LOCK: begin
                s_next.locked = 1'b1;
                s_next.lockIiSi = cmdArg;
              end
              `SMTB_CMD_UNLOCK: s_next.locked = 1'b0;
              `SMTB_CMD_RESTORE: begin
                s_next.alert = 1'b0;
                s_next.capSel = 1'b0;
                s_next.idSel = 1'b0;
                s_next.raSel = 1'b0;
              end
              // Unknown command codes are ignored; a same-cycle setting error must survive
              default: ;
            endcase
          end else if (intKind == SMTB_K_COMMA) begin
            s_next.aicbValid = 1'b1;
            s_next.aicbMb = intMa;
          end
        end
      end
      SMTB_S_WAIT: begin
        if (dlyBus.done) begin
          s_next.fsm = SMTB_S_SEND;
        end
      end
      SMTB_S_SEND: begin
        s_next.fsm = SMTB_S_IDLE;
        s_next.replyStrobe = s_reg.txEnable;
        s_next.replyKind = s_reg.kind;
        s_next.replyAlert = s_reg.alert;
        s_next.replyCap = s_reg.capPend;
        s_next.capPend = 1'b0;
      end
    endcase

    // A fault latches until reset so a stuck carrier cannot come back on
    if (txCarrierOn && s_reg.txEnable) begin
      if (s_reg.cwCnt >= CW_LIMIT) begin
        s_next.cwFault = 1'b1;
        s_next.txEnable = 1'b0;
      end else begin
        s_next.cwCnt = s_reg.cwCnt + 24'h000001;
      end
    end else begin
      s_next.cwCnt = 24'h000000;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.fsm <= SMTB_S_IDLE;
      s_reg.alertRr <= `SMTB_ALERTRR_RST;
      s_reg.onGnd <= 1'b1;
      s_reg.txEnable <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dlyBus.start = s_reg.dlyStart;
  assign dlyBus.cycles = {1'b0, s_reg.turn} + {1'b0, s_reg.range};

  // ==========================================================
  // Outputs
  assign replyStrobe = s_reg.replyStrobe;
  assign replyKind = s_reg.replyKind;
  assign replyAlert = s_reg.replyAlert;
  assign replyCapAnnounce = s_reg.replyCap;
  assign replyOnGround = s_reg.onGnd;
  assign replyAltStatus = s_reg.altSt[8];
  assign replyAltDigits = {s_reg.altSt[5:0], digC, digD};
  assign replyAltFeet = s_reg.altFt;
  assign replyModeA = s_reg.alert ? s_reg.modeAT : s_reg.modeA;
  assign beaconAddress = s_reg.addr;
  assign aicbValid = s_reg.aicbValid;
  assign aicbMb = s_reg.aicbMb;
  assign elmEchoValid = s_reg.elmValid;
  assign elmEchoData = s_reg.elmData;
  assign raBroadcast = s_reg.raBroadcast;
  assign gicbAck = s_reg.gicbAck;
  assign gicbData = s_reg.gicbData;
  assign cfgAck = s_reg.cfgAck;
  assign cfgError = s_reg.cfgError;
  assign powerAtten = s_reg.atten;
  assign rxTrigLevel = s_reg.rxTrig;
  assign squitterEnable = 1'b0;
  assign txEnable = s_reg.txEnable;
  assign cwFault = s_reg.cwFault;
  assign busy = s_reg.fsm != SMTB_S_IDLE;
endmodule

// ### tb/smtb_monitor.sv
// Checker for the test beacon control block, bound to its top
`timescale 1ns/1ps
module smtb_monitor
  import smtb_pkg::*;
#(
  parameter int CW_CYCLES = 25000
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic txCarrierOn,
  input wire logic cfgWe,
  input wire logic cfgAck,
  input wire logic gicbValid,
  input wire logic gicbAck,
  input wire logic elmInValid,
  input wire logic [79:0] elmInData,
  input wire logic elmEchoValid,
  input wire logic [79:0] elmEchoData,
  input wire logic replyStrobe,
  input wire logic busy,
  input wire logic replyAltStatus,
  input wire logic [11:0] replyAltDigits,
  input wire logic [5:0] powerAtten,
  input wire logic [5:0] rxTrigLevel,
  input wire logic squitterEnable,
  input wire logic txEnable,
  input wire logic cwFault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Carrier run length, saturating
  logic [31:0] cwRun_reg;
  always_ff @(posedge ref_clk) begin
    if (rst || !txCarrierOn) begin
      cwRun_reg <= '0;
    end else if (cwRun_reg < CW_CYCLES + 3) begin
      cwRun_reg <= cwRun_reg + 1;
    end
  end
  // ==========================================
  // Properties
  property p_cw;
    cwRun_reg == CW_CYCLES + 3 |-> cwFault && !txEnable;
  endproperty
  a_cw: assert property (p_cw) else $error("carrier run without fault");
  property p_txoff;
    cwFault |-> !txEnable && !replyStrobe ##1 cwFault;
  endproperty
  a_txoff: assert property (p_txoff) else $error("transmit after fault");
  property p_squit;
    !squitterEnable;
  endproperty
  a_squit: assert property (p_squit) else $error("squitter enabled");
  property p_cfg;
    cfgWe |=> cfgAck;
  endproperty
  a_cfg: assert property (p_cfg) else $error("setting write not answered");
  property p_lim;
    powerAtten <= 6'h28 && rxTrigLevel <= 6'h28;
  endproperty
  a_lim: assert property (p_lim) else $error("level setting out of range");
  property p_alt;
    replyAltStatus |-> replyAltDigits[5:0] inside {6'h00, 6'h2F, 6'h3F};
  endproperty
  a_alt: assert property (p_alt) else $error("status code decodes as altitude");
  property p_gicb;
    gicbValid |=> gicbAck;
  endproperty
  a_gicb: assert property (p_gicb) else $error("register read not answered");
  property p_elm;
    elmInValid |=> elmEchoValid && elmEchoData == $past(elmInData);
  endproperty
  a_elm: assert property (p_elm) else $error("long segment not echoed");
  property p_busy;
    replyStrobe |-> $past(busy);
  endproperty
  a_busy: assert property (p_busy) else $error("reply without delay phase");
endmodule

bind smtb_top smtb_monitor #(.CW_CYCLES(CW_CYCLES)) u_mon (.ref_clk, .rst, .txCarrierOn, .cfgWe, .cfgAck,
  .gicbValid, .gicbAck, .elmInValid, .elmInData, .elmEchoValid, .elmEchoData, .replyStrobe, .busy,
  .replyAltStatus, .replyAltDigits, .powerAtten, .rxTrigLevel, .squitterEnable, .txEnable, .cwFault);

// ### tb/smtb_interrogator.sv
// Ground interrogator model driving uplink requests into the beacon
`timescale 1ns/1ps
module smtb_interrogator (
  input wire logic ref_clk,
  input wire logic gicbAck,
  input wire logic [55:0] gicbData,
  output logic intValid,
  output logic [2:0] intKind,
  output logic [4:0] intRr,
  output logic [55:0] intMa,
  output logic [5:0] intMspCh,
  output logic [7:0] intMspSr,
  output logic elmInValid,
  output logic [79:0] elmInData,
  output logic gicbValid,
  output logic [7:0] gicbBds
);
  initial {intValid, elmInValid, gicbValid, intKind, intRr, intMa, intMspCh, intMspSr, elmInData, gicbBds} = '0;
  // Released lines show the inverse, never a stale copy
  task automatic up(input logic [2:0] k, input logic [4:0] r, input logic [55:0] m,
    input logic [5:0] c, input logic [7:0] s);
    {intKind, intRr, intMa, intMspCh, intMspSr} = {k, r, m, c, s};
    intValid = 1'b1;
    @(posedge ref_clk);
    #1;
    intValid = 1'b0;
    {intKind, intRr, intMa, intMspCh, intMspSr} = ~{k, r, m, c, s};
  endtask
  task automatic elm(input logic [79:0] d);
    elmInData = d;
    elmInValid = 1'b1;
    @(posedge ref_clk);
    #1;
    elmInValid = 1'b0;
    elmInData = ~d;
  endtask
  task automatic gicb(input logic [7:0] b, output logic [55:0] d);
    gicbBds = b;
    gicbValid = 1'b1;
    @(posedge ref_clk);
    #1;
    gicbValid = 1'b0;
    gicbBds = ~b;
    d = (gicbAck === 1'b1) ? gicbData : 'x;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// ### tb/tb_site_monitor_test_beacon_control.sv
// Self-checking bench for the test beacon control block
`timescale 1ns/1ps
`include "smtb_params.svh"
module tb_site_monitor_test_beacon_control;
  import smtb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cfgWe = 1'b0;
  logic txCarrierOn = 1'b0;
  logic [4:0] cfgSel = '0;
  logic [55:0] cfgData = '0;
  logic intValid, elmInValid, gicbValid, replyStrobe, replyAlert, replyCapAnnounce, replyOnGround;
  logic replyAltStatus, aicbValid, elmEchoValid, raBroadcast, gicbAck, cfgAck, cfgError;
  logic squitterEnable, txEnable, cwFault, busy, rAlert, rCap, raSeen;
  logic [2:0] intKind, replyKind, rKind;
  logic [4:0] intRr;
  logic [5:0] intMspCh, powerAtten, rxTrigLevel;
  logic [7:0] intMspSr, gicbBds;
  logic [11:0] replyAltDigits, replyModeA;
  logic [16:0] replyAltFeet;
  logic [23:0] beaconAddress;
  logic [55:0] intMa, aicbMb, gicbData, gd;
  logic [79:0] elmInData, elmEchoData;
  int err_count = 0;
  int n_tests = 0;
  int idx, nRep, k;

  always #4 ref_clk = ~ref_clk;

  smtb_top #(.CW_CYCLES(20)) dut (.ref_clk, .rst, .intValid, .intKind, .intRr, .intMa, .intMspCh, .intMspSr,
    .elmInValid, .elmInData, .gicbValid, .gicbBds, .cfgWe, .cfgSel, .cfgData, .txCarrierOn, .replyStrobe,
    .replyKind, .replyAlert, .replyCapAnnounce, .replyOnGround, .replyAltStatus, .replyAltDigits, .replyAltFeet,
    .replyModeA, .beaconAddress, .aicbValid, .aicbMb, .elmEchoValid, .elmEchoData, .raBroadcast, .gicbAck,
    .gicbData, .cfgAck, .cfgError, .powerAtten, .rxTrigLevel, .squitterEnable, .txEnable, .cwFault, .busy);
  smtb_interrogator gnd (.ref_clk, .gicbAck, .gicbData, .intValid, .intKind, .intRr, .intMa, .intMspCh,
    .intMspSr, .elmInValid, .elmInData, .gicbValid, .gicbBds);

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic cfg(input logic [4:0] s, input logic [55:0] d, input logic e);
    int i;
    {cfgSel, cfgData, cfgWe} = {s, d, 1'b1};
    tick();
    cfgWe = 1'b0;
    cfgData = ~d;
    for (i = 0; i < 4 && cfgAck !== 1'b1; i++) tick();
    if (i == 4) begin
      err_count++;
      complete_run();
    end
    chk(cfgError, e);
    tick();
  endtask
  // Fixed window so a late second reply is seen too; costs run time
  task automatic rep(input int e);
    int i;
    {idx, nRep, raSeen} = '0;
    for (i = 0; i < 40; i++) begin
      if (raBroadcast === 1'b1) raSeen = 1'b1;
      if (replyStrobe === 1'b1) begin
        nRep++;
        idx = i;
        {rKind, rAlert, rCap} = {replyKind, replyAlert, replyCapAnnounce};
      end
      tick();
    end
    chk(idx, e);
    chk(nRep, e != 0);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({txEnable, replyOnGround, squitterEnable, busy}, 4'hC);
    cfg(`SMTB_CFG_ATTEN, 56'h28, 1'b0);
    chk(powerAtten, 6'h28);
    cfg(`SMTB_CFG_ATTEN, 56'h29, 1'b1);
    chk(powerAtten, 6'h28);
    cfg(`SMTB_CFG_RXTRIG, 56'h29, 1'b1);
    cfg(`SMTB_CFG_ALERTRR, 56'h0F, 1'b1);
    cfg(5'h11, 56'h00, 1'b1);
    cfg(`SMTB_CFG_ALTST, 56'h0C0, 1'b1);
    cfg(`SMTB_CFG_ALTST, 56'h105, 1'b0);
    chk({replyAltStatus, replyAltDigits}, {1'b1, 12'h140});
    cfg(`SMTB_CFG_ALTFT, 56'h00064, 1'b1);
    cfg(`SMTB_CFG_ALTFT, 56'h13880, 1'b0);
    chk(replyAltFeet, 17'h13880);
    cfg(`SMTB_CFG_ADDR, 56'hA5C3E1, 1'b0);
    chk(beaconAddress, 24'hA5C3E1);
    cfg(`SMTB_CFG_TURN, 56'h3, 1'b0);
    cfg(`SMTB_CFG_RANGE, 56'h2, 1'b0);
    cfg(`SMTB_CFG_CAPT, 56'h1C2D3E4F506172, 1'b0);
    cfg(`SMTB_CFG_ACIDT, 56'h0048454C4C4F21, 1'b0);
    cfg(`SMTB_CFG_RAT, 56'h30A1B2C3D4E5F6, 1'b0);
    for (k = 0; k < 4; k++) begin
      gnd.up(k[2:0], 5'h00, 56'h0, 6'h00, 8'h00);
      rep(9);
      chk(rKind, k[2:0]);
    end
    gnd.up(3'h3, 5'h00, 56'h0, 6'h00, 8'h00);
    tick();
    gnd.up(3'h3, 5'h00, 56'h0, 6'h00, 8'h00);
    rep(7);
    gnd.up(3'h4, 5'h00, 56'h0123456789ABCD, 6'h00, 8'h00);
    chk({aicbValid, aicbMb}, {1'b1, 56'h0123456789ABCD});
    rep(9);
    gnd.elm(80'hFEDCBA98765432100123);
    chk({elmEchoValid, elmEchoData}, {1'b1, 80'hFEDCBA98765432100123});
    gnd.up(3'h5, 5'h00, {`SMTB_CMD_CAP, 48'h0}, `SMTB_MSP_CH, `SMTB_MSP_SR);
    rep(9);
    chk(rCap, 1'b1);
    gnd.up(3'h3, 5'h00, 56'h0, 6'h00, 8'h00);
    rep(9);
    chk(rCap, 1'b0);
    gnd.up(3'h4, 5'h00, {`SMTB_MA_KEY, `SMTB_CMD_RA, 40'h0}, 6'h00, 8'h00);
    rep(9);
    chk(raSeen, 1'b1);
    gnd.up(3'h4, 5'h00, {`SMTB_MA_KEY, `SMTB_CMD_ID, 40'h0}, 6'h00, 8'h00);
    rep(9);
    gnd.gicb(`SMTB_BDS_STAT, gd);
    chk(gd[51:49], 3'h7);
    gnd.gicb(`SMTB_BDS_CAP, gd);
    chk(gd, 56'h1C2D3E4F506172);
    gnd.gicb(`SMTB_BDS_ID, gd);
    chk(gd, 56'h0048454C4C4F21);
    gnd.gicb(`SMTB_BDS_RA, gd);
    chk(gd, 56'h30A1B2C3D4E5F6);
    cfg(`SMTB_CFG_MODEAT, 56'h7A5, 1'b0);
    cfg(`SMTB_CFG_ALERTRR, 56'h12, 1'b0);
    gnd.up(3'h3, 5'h12, 56'h0, 6'h00, 8'h00);
    rep(9);
    chk({rAlert, replyModeA}, {1'b1, 12'h7A5});
    gnd.up(3'h5, 5'h00, {`SMTB_CMD_LOCK, 8'h2A, 40'h0}, `SMTB_MSP_CH, `SMTB_MSP_SR);
    rep(9);
    gnd.gicb(`SMTB_BDS_LOCK, gd);
    chk(gd, {1'b1, 47'h0, 8'h2A});
    gnd.up(3'h1, 5'h00, 56'h0, 6'h00, 8'h00);
    rep(0);
    gnd.up(3'h5, 5'h00, {`SMTB_CMD_UNLOCK, 48'h0}, `SMTB_MSP_CH, `SMTB_MSP_SR);
    rep(9);
    gnd.up(3'h1, 5'h00, 56'h0, 6'h00, 8'h00);
    rep(9);
    txCarrierOn = 1'b1;
    repeat (25) tick();
    txCarrierOn = 1'b0;
    chk({cwFault, txEnable}, 2'h2);
    gnd.up(3'h3, 5'h00, 56'h0, 6'h00, 8'h00);
    rep(0);
    complete_run();
  end
endmodule
